// *** reset_irq_defs.svh ***
`ifndef RESET_IRQ_DEFS_SVH
`define RESET_IRQ_DEFS_SVH

// ----------------------------------------------------------------------
// Register indices; the byte address on the bus is four times the index.
// ----------------------------------------------------------------------
`define IDX_RESET_CAUSE 6'h34
`define IDX_PROC_CTRL 6'h35
`define IDX_TIMER_MASK 6'h39
`define IDX_IRQ_FLAGS 6'h3A
`define IDX_IRQ_ENABLE 6'h3B
`define IDX_PROC_STATUS 6'h3F

// ----------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------
`define BIT_POWER_ON 0
`define BIT_EXT_RESET 1
`define BIT_BROWNOUT 2
`define BIT_WATCHDOG 3
`define BIT_EXT_IRQ 6
`define BIT_PIN_CHANGE 5
`define BIT_TIMER_OVF_EN 1
`define BIT_GLOBAL_EN 7

// ----------------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------------
`define RST_IRQ_FLAGS 8'h00
`define RST_IRQ_ENABLE 8'h00
`define RST_SENSE 2'h0

// ----------------------------------------------------------------------
// Timing: reset pulse length and start-up delay in clk_sys cycles.
// ----------------------------------------------------------------------
`define WDT_PULSE_NS 8
`define CLK_PERIOD_NS 8
`define WDT_PULSE_CYCLES (`WDT_PULSE_NS / `CLK_PERIOD_NS)
`define START_DELAY_CYCLES 12'h0100

`endif

// *** reset_irq_pkg.sv ***
package reset_irq_pkg;

  // External pin trigger selection.
  typedef enum logic [1:0] {
    SENSE_LOW = 2'b00,
    SENSE_ANY = 2'b01,
    SENSE_FALL = 2'b10,
    SENSE_RISE = 2'b11
  } sense_type;

  // Core reset sequencer.
  typedef enum logic [1:0] {
    RST_IDLE = 2'b00,
    RST_PULSE = 2'b01,
    RST_DELAY = 2'b10
  } reset_state_type;

  // Vector numbers handed to the core.
  typedef enum logic [1:0] {
    VEC_NONE = 2'b00,
    VEC_EXT = 2'b01,
    VEC_PIN = 2'b10
  } vector_type;

endpackage : reset_irq_pkg

// *** reset_flags_and_irq_control.sv ***
// How it works
// - Watchdog time-out gives a one-cycle reset pulse; delay starts at its end.
// - Two-flag variant: bit 1 set by external reset, kept by watchdog reset.
// - Two-flag variant: bit 0 set by power-on only; bits 7..2 read zero.
// - Four-flag: bit 3 set by watchdog reset, cleared by power-on or write 0.
// - Four-flag: bit 2 set by brown-out, cleared by power-on or write 0.
// - Four-flag: bit 1 set by external reset, cleared by power-on or write 0.
// - Four-flag: bit 0 set by power-on, cleared only by writing zero.
// - Four-flag register bits 7..4 read zero and ignore writes.
// - Accepting an interrupt clears the global enable.
// - Return from interrupt sets the global enable.
// - Vectoring clears the pending flag of the interrupt served.
// - A disabled interrupt still sets its flag, which stays pending.
// - Pending flags wait for the global enable, then serve by priority.
// - Low-level external request has no flag; it lasts while the pin is low.
// - Entry and return never save or restore the status register.
// - Enable bit 6 with global enable allows external pin requests, vector 1.
// - Enable bit 5 with global enable allows pin change requests, vector 2.
// - Flag bit 6 set by pin event, cleared on vectoring, write one, level mode.
// - Flag bit 5 set by pin change, cleared on vectoring or write one.
// - Mask and flag registers: bit 7 and bits 4..0 read zero.
// - Timer mask bits 7..2 read zero and are not writable.
// - Sense field: 00 low, 01 any change, 10 falling, 11 rising.
`include "reset_irq_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module reset_flags_and_irq_control
  import reset_irq_pkg::*;
#(
  parameter bit FOUR_FLAG = 1'b1
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic extResetPinN,
  input wire logic brownoutDetect,
  input wire logic wdtTimeout,
  input wire logic extIrqPin,
  input wire logic [5:0] pinLevel,
  input wire logic irqAck,
  input wire logic returnFromInterrupt,
  output logic irqRequest,
  output logic [1:0] irqVector,
  output logic globalEnable,
  output logic wdtResetPulse,
  output logic coreReset
);

  // --------------------------------------------------------------------
  // Pin synchronisers.
  // --------------------------------------------------------------------
  localparam int NPINS = 9;
  localparam logic [11:0] ONE_DELAY = 12'h001;
  localparam logic [11:0] PULSE_LEN = 12'(`WDT_PULSE_CYCLES);

  logic [NPINS-1:0] rawPins;
  logic [NPINS-1:0] syncA;
  logic [NPINS-1:0] syncB;
  logic [NPINS-1:0] syncC;
  logic [NPINS-1:0] stable;
  logic [NPINS-1:0] changed;
  logic [2:0] primeCount;
  logic primed;

  assign rawPins = {brownoutDetect, extResetPinN, extIrqPin, pinLevel};

  // Each pin passes three flops; a value counts once stages two and three
  // agree, which filters a sample caught during a transition.
  genvar gi;
  generate
    for (gi = 0; gi < NPINS; gi++) begin : g_sync
      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          syncA[gi] <= 1'b0;
          syncB[gi] <= 1'b0;
          syncC[gi] <= 1'b0;
          stable[gi] <= 1'b0;
        end else begin
          syncA[gi] <= rawPins[gi];
          syncB[gi] <= syncA[gi];
          syncC[gi] <= syncB[gi];
          if (syncB[gi] == syncC[gi]) begin
            stable[gi] <= syncC[gi];
          end
        end
      end
      assign changed[gi] = primed && (syncB[gi] == syncC[gi]) &&
                           (syncC[gi] != stable[gi]);
    end
  endgenerate

  // Events are held off until the stable stage holds the first settled pin
  // values, so that leaving reset does not look like a pin change.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      primeCount <= 3'h0;
    end else if (!primed) begin
      primeCount <= primeCount + 3'h1;
    end
  end
  assign primed = (primeCount == 3'h4);

  logic extLevel;
  logic extResetActive;
  logic brownoutActive;
  assign extLevel = stable[6];
  assign extResetActive = primed && !stable[7];
  assign brownoutActive = primed && stable[8];

  // --------------------------------------------------------------------
  // Bus write and read decode.
  // --------------------------------------------------------------------
  logic awHeld;
  logic wHeld;
  logic [5:0] wrIdx;
  logic [7:0] wrByte;
  logic wrLane;
  logic wrFire;
  logic [7:0] resetCause;
  logic [7:0] irqFlags;
  logic [7:0] irqEnable;
  logic [1:0] senseCtrl;
  logic timerOvfEnable;

  assign wrFire = awHeld && wHeld && !s_axi_bvalid;

  // Returns whether an index holds a register.
  function automatic logic isMapped(input logic [5:0] idx);
    isMapped = (idx == `IDX_RESET_CAUSE) || (idx == `IDX_PROC_CTRL) ||
               (idx == `IDX_TIMER_MASK) || (idx == `IDX_IRQ_FLAGS) ||
               (idx == `IDX_IRQ_ENABLE) || (idx == `IDX_PROC_STATUS);
  endfunction : isMapped

  logic [7:0] readByte;
  logic [5:0] rdIdx;
  assign rdIdx = s_axi_araddr[7:2];

  // Read mux; unused bits read as zero.
  always_comb begin
    readByte = 8'h00;
    unique case (rdIdx)
      `IDX_RESET_CAUSE: readByte = resetCause;
      `IDX_PROC_CTRL: readByte = {6'h00, senseCtrl};
      `IDX_TIMER_MASK: readByte = {6'h00, timerOvfEnable, 1'b0};
      `IDX_IRQ_FLAGS: readByte = irqFlags;
      `IDX_IRQ_ENABLE: readByte = irqEnable;
      `IDX_PROC_STATUS: readByte = {globalEnable, 7'h00};
      default: readByte = 8'h00;
    endcase
  end

  // Write channel: address and data are taken in either order and the
  // response is raised once both are held.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      wrIdx <= 6'h00;
      wrByte <= 8'h00;
      wrLane <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        wrIdx <= s_axi_awaddr[7:2];
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wrByte <= s_axi_wdata[7:0];
        wrLane <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wrFire) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= isMapped(wrIdx) ? 2'b00 : 2'b10;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Read channel: one read at a time, answered the cycle after address.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h00_0000, readByte};
      s_axi_rresp <= isMapped(rdIdx) ? 2'b00 : 2'b10;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  logic wrOk;
  assign wrOk = wrFire && wrLane;

  // --------------------------------------------------------------------
  // Reset cause flags.
  // --------------------------------------------------------------------
  logic wdtEvent;
  logic extEvent;
  logic boEvent;
  logic extSeen;
  logic boSeen;
  logic causeWr;
  assign causeWr = wrOk && (wrIdx == `IDX_RESET_CAUSE);
  assign wdtEvent = wdtTimeout && primed;
  assign extEvent = extResetActive && !extSeen;
  assign boEvent = brownoutActive && !boSeen;

  // Remembers an active reset level so each reset counts once.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      extSeen <= 1'b0;
      boSeen <= 1'b0;
    end else begin
      extSeen <= extResetActive;
      boSeen <= brownoutActive;
    end
  end

  // The block's own reset stands for power-on: it sets the power-on flag
  // and clears the others. A set in the same cycle as a write of zero wins.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      resetCause <= 8'h01;
    end else begin
      resetCause[7:4] <= 4'h0;
      if (causeWr && !wrByte[`BIT_POWER_ON]) begin
        resetCause[`BIT_POWER_ON] <= 1'b0;
      end
      if (extEvent) begin
        resetCause[`BIT_EXT_RESET] <= 1'b1;
      end else if (causeWr && !wrByte[`BIT_EXT_RESET]) begin
        resetCause[`BIT_EXT_RESET] <= 1'b0;
      end
      if (!FOUR_FLAG) begin
        resetCause[3:2] <= 2'b00;
      end else begin
        if (boEvent) begin
          resetCause[`BIT_BROWNOUT] <= 1'b1;
        end else if (causeWr && !wrByte[`BIT_BROWNOUT]) begin
          resetCause[`BIT_BROWNOUT] <= 1'b0;
        end
        if (wdtEvent) begin
          resetCause[`BIT_WATCHDOG] <= 1'b1;
        end else if (causeWr && !wrByte[`BIT_WATCHDOG]) begin
          resetCause[`BIT_WATCHDOG] <= 1'b0;
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Core reset sequencer with start-up delay.
  // --------------------------------------------------------------------
  reset_state_type rstState;
  logic [11:0] delayCount;

  // A watchdog time-out gives a one-cycle pulse; the delay counts from the
  // cycle after it. External and brown-out resets hold the core while they
  // last and then run the same delay.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rstState <= RST_DELAY;
      delayCount <= `START_DELAY_CYCLES;
      wdtResetPulse <= 1'b0;
      coreReset <= 1'b1;
    end else begin
      wdtResetPulse <= 1'b0;
      unique case (rstState)
        RST_IDLE: begin
          if (extResetActive || brownoutActive) begin
            rstState <= RST_DELAY;
            delayCount <= `START_DELAY_CYCLES;
            coreReset <= 1'b1;
          end else if (wdtEvent) begin
            rstState <= RST_PULSE;
            delayCount <= PULSE_LEN;
            wdtResetPulse <= 1'b1;
            coreReset <= 1'b1;
          end
        end
        RST_PULSE: begin
          rstState <= RST_DELAY;
          delayCount <= `START_DELAY_CYCLES;
        end
        RST_DELAY: begin
          if (extResetActive || brownoutActive) begin
            delayCount <= `START_DELAY_CYCLES;
          end else if (delayCount <= ONE_DELAY) begin
            rstState <= RST_IDLE;
            coreReset <= 1'b0;
          end else begin
            delayCount <= delayCount - ONE_DELAY;
          end
        end
        default: begin
          rstState <= RST_IDLE;
          coreReset <= 1'b0;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Interrupt control registers.
  // --------------------------------------------------------------------
  logic levelMode;
  logic extTrig;
  logic pinChangeEvent;
  logic extPending;
  logic pinPending;
  logic ackExt;
  logic ackPin;
  assign levelMode = (sense_type'(senseCtrl) == SENSE_LOW);
  assign pinChangeEvent = |changed[5:0];
  assign ackExt = irqAck && (irqVector == VEC_EXT);
  assign ackPin = irqAck && (irqVector == VEC_PIN);

  // Trigger selection for the external pin; the pin counts even when it
  // is driven as an output, as its level is read back here.
  always_comb begin
    extTrig = 1'b0;
    unique case (sense_type'(senseCtrl))
      SENSE_LOW: extTrig = 1'b0;
      SENSE_ANY: extTrig = changed[6];
      SENSE_FALL: extTrig = changed[6] && !syncC[6];
      SENSE_RISE: extTrig = changed[6] && syncC[6];
    endcase
  end

  // Enable and control registers written by software.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      irqEnable <= `RST_IRQ_ENABLE;
      senseCtrl <= `RST_SENSE;
      timerOvfEnable <= 1'b0;
    end else if (wrOk) begin
      if (wrIdx == `IDX_IRQ_ENABLE) begin
        irqEnable <= wrByte & 8'h60;
      end
      if (wrIdx == `IDX_PROC_CTRL) begin
        senseCtrl <= wrByte[1:0];
      end
      if (wrIdx == `IDX_TIMER_MASK) begin
        timerOvfEnable <= wrByte[`BIT_TIMER_OVF_EN];
      end
    end
  end

  // Flags are set whatever the enables; a set beats a clear in one cycle.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      irqFlags <= `RST_IRQ_FLAGS;
    end else begin
      if (levelMode) begin
        irqFlags[`BIT_EXT_IRQ] <= 1'b0;
      end else if (extTrig) begin
        irqFlags[`BIT_EXT_IRQ] <= 1'b1;
      end else if (ackExt || (wrOk && wrIdx == `IDX_IRQ_FLAGS &&
                              wrByte[`BIT_EXT_IRQ])) begin
        irqFlags[`BIT_EXT_IRQ] <= 1'b0;
      end
      if (pinChangeEvent) begin
        irqFlags[`BIT_PIN_CHANGE] <= 1'b1;
      end else if (ackPin || (wrOk && wrIdx == `IDX_IRQ_FLAGS &&
                              wrByte[`BIT_PIN_CHANGE])) begin
        irqFlags[`BIT_PIN_CHANGE] <= 1'b0;
      end
    end
  end

  // Global enable: acceptance clears it, return sets it, software writes
  // it. Only this bit is touched; the rest of the core status is the
  // handler's own business.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      globalEnable <= 1'b0;
    end else if (irqAck) begin
      globalEnable <= 1'b0;
    end else if (returnFromInterrupt) begin
      globalEnable <= 1'b1;
    end else if (wrOk && wrIdx == `IDX_PROC_STATUS) begin
      globalEnable <= wrByte[`BIT_GLOBAL_EN];
    end
  end

  // --------------------------------------------------------------------
  // Request to the core.
  // --------------------------------------------------------------------
  assign extPending = irqEnable[`BIT_EXT_IRQ] &&
                      (levelMode ? (primed && !extLevel)
                                 : irqFlags[`BIT_EXT_IRQ]);
  assign pinPending = irqEnable[`BIT_PIN_CHANGE] &&
                      irqFlags[`BIT_PIN_CHANGE];

  // The request is withdrawn on acceptance so one interrupt is taken per
  // enable; the lower vector wins when both are pending.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      irqRequest <= 1'b0;
      irqVector <= VEC_NONE;
    end else if (irqAck || !globalEnable || coreReset) begin
      irqRequest <= 1'b0;
      irqVector <= VEC_NONE;
    end else if (extPending) begin
      irqRequest <= 1'b1;
      irqVector <= VEC_EXT;
    end else if (pinPending) begin
      irqRequest <= 1'b1;
      irqVector <= VEC_PIN;
    end else begin
      irqRequest <= 1'b0;
      irqVector <= VEC_NONE;
    end
  end

endmodule : reset_flags_and_irq_control

`default_nettype wire

// *** reset_irq_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "reset_irq_defs.svh"

module reset_irq_checker
  import reset_irq_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic wdtTimeout,
  input wire logic irqAck,
  input wire logic returnFromInterrupt,
  input wire logic irqRequest,
  input wire logic [1:0] irqVector,
  input wire logic globalEnable,
  input wire logic wdtResetPulse,
  input wire logic coreReset
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  logic [5:0] readIndex;

  // Remembers which register the pending read answer belongs to.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      readIndex <= 6'h00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      readIndex <= s_axi_araddr[7:2];
    end
  end

  // --------------------------------------------------------------------
  // Reset sequencing, interrupt hand-off and reserved bits.
  // --------------------------------------------------------------------
  a_wdt_pulse_start: assert property (
    wdtTimeout && !coreReset |=> wdtResetPulse && coreReset)
    else $error("Watchdog time-out gave no reset pulse.");
  a_wdt_pulse_once: assert property (
    wdtResetPulse |=> !wdtResetPulse)
    else $error("Watchdog reset pulse longer than one cycle.");
  a_wdt_delay_hold: assert property (
    wdtResetPulse |=> coreReset [*8])
    else $error("Core left reset too soon after the pulse.");
  a_ack_clears_gie: assert property (
    irqAck |=> !globalEnable)
    else $error("Global enable stayed set after acceptance.");
  a_return_from_interrupt_sets_gie: assert property (
    returnFromInterrupt && !irqAck |=> globalEnable)
    else $error("Return did not set the global enable.");
  a_ack_ends_req: assert property (
    irqAck |=> !irqRequest)
    else $error("Request stayed up after acceptance.");
  a_req_needs_gie: assert property (
    irqRequest |-> $past(globalEnable))
    else $error("Request raised while global enable was clear.");
  a_cause_high_zero: assert property (
    s_axi_rvalid && readIndex == `IDX_RESET_CAUSE |-> s_axi_rdata[31:4] == '0)
    else $error("Reset cause upper bits not zero.");
  a_mask_reserved_zero: assert property (
    s_axi_rvalid && (readIndex == `IDX_IRQ_FLAGS ||
    readIndex == `IDX_IRQ_ENABLE) |-> s_axi_rdata[31:7] == '0 &&
    s_axi_rdata[4:0] == '0)
    else $error("Reserved enable or flag bits not zero.");
  a_timer_reserved_zero: assert property (
    s_axi_rvalid && readIndex == `IDX_TIMER_MASK |-> s_axi_rdata[31:2] == '0)
    else $error("Timer mask reserved bits not zero.");

  c_wdt_reset: cover property (wdtResetPulse);
  c_ext_taken: cover property (irqAck && irqVector == VEC_EXT);
  c_pin_taken: cover property (irqAck && irqVector == VEC_PIN);
endmodule : reset_irq_checker

bind reset_flags_and_irq_control reset_irq_checker u_reset_irq_checker (
  .clk_sys, .nrst, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .wdtTimeout, .irqAck, .returnFromInterrupt,
  .irqRequest, .irqVector, .globalEnable, .wdtResetPulse, .coreReset);

`default_nettype wire

// *** core_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module core_model (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic irqRequest,
  input wire logic [3:0] ackDelay,
  output logic irqAck
);
  logic [3:0] waitCount;

  // Takes an offered vector once it has stood for ackDelay cycles.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      waitCount <= 4'h0;
      irqAck <= 1'b0;
    end else if (irqRequest && !irqAck && waitCount >= ackDelay) begin
      waitCount <= 4'h0;
      irqAck <= 1'b1;
    end else begin
      waitCount <= (irqRequest && !irqAck) ? waitCount + 4'h1 : 4'h0;
      irqAck <= 1'b0;
    end
  end
endmodule : core_model

`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "reset_irq_defs.svh"
`define CHECK(g, e) begin samplesChecked++; if ((g) !== (e)) begin \
  failures++; $display("wrong value at %0t: got %h want %h", $time, g, e); \
  end end
`define WAIT_FOR(c) begin int w; w = 0; while (!(c) && w < 600) begin \
  @(posedge clk_sys); w++; end if (!(c)) begin failures++; test_done(); end end

module testbench
  import reset_irq_pkg::*;
;
  logic clk_sys = 1'b0, nrst = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic extResetPinN = 1'b1, brownoutDetect = 1'b0, wdtTimeout = 1'b0;
  logic extIrqPin = 1'b0, returnFromInterrupt = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'h1, ackDelay = 4'h0;
  logic [5:0] pinLevel = 6'h00;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, irqAck, irqRequest, globalEnable, wdtResetPulse, coreReset;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp, irqVector, wantVec;
  logic [33:0] wantRead;
  logic [33:0] readQ[$];
  logic [1:0] vecQ[$];
  int failures = 0, samplesChecked = 0, seed = 27274;

  reset_flags_and_irq_control u_reset_flags_and_irq_control (
    .clk_sys, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .extResetPinN, .brownoutDetect, .wdtTimeout, .extIrqPin, .pinLevel,
    .irqAck, .returnFromInterrupt, .irqRequest, .irqVector, .globalEnable,
    .wdtResetPulse, .coreReset);
  core_model u_core_model (.clk_sys, .nrst, .irqRequest, .ackDelay, .irqAck);

  // Free-running 125 MHz system clock.
  always #4 clk_sys = ~clk_sys;

  // Prints the counts and the verdict, then ends the run.
  task automatic test_done;
    $display("Mismatches %0d, comparisons %0d", failures, samplesChecked);
    if (failures == 0 && samplesChecked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done

  // One bus write of the low byte to a register index.
  task automatic bus_write(input logic [5:0] idx, input logic [7:0] data);
    int n;
    n = 0;
    @(posedge clk_sys);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {24'h00_0000, data};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 50);
    s_axi_bready <= 1'b0;
    if (!s_axi_bvalid) begin failures++; test_done(); end
    `CHECK(s_axi_bresp, 2'b00)
  endtask : bus_write

  // One bus read; the expected answer is noted before the request goes out.
  task automatic bus_read(input logic [5:0] idx, input logic [7:0] data,
                          input logic [1:0] resp);
    int n;
    n = 0;
    @(posedge clk_sys);
    readQ.push_back({resp, 24'h00_0000, data});
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 50);
    s_axi_rready <= 1'b0;
    if (!s_axi_rvalid) begin failures++; test_done(); end
  endtask : bus_read

  // Matches each read answer and each taken vector with the oldest note.
  always @(posedge clk_sys) begin
    if (s_axi_rvalid && s_axi_rready) begin
      wantRead = readQ.size() ? readQ.pop_front() : 'x;
      `CHECK({s_axi_rresp, s_axi_rdata}, wantRead)
    end
    if (irqAck) begin
      wantVec = vecQ.size() ? vecQ.pop_front() : 'x;
      `CHECK(irqVector, wantVec)
    end
  end

  // --------------------------------------------------------------------
  // Main sequence.
  // --------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    `WAIT_FOR(!coreReset)
    bus_read(`IDX_RESET_CAUSE, 8'h01, 2'b00);
    bus_read(`IDX_IRQ_FLAGS, 8'h00, 2'b00);
    bus_write(`IDX_IRQ_ENABLE, 8'hFF);
    bus_read(`IDX_IRQ_ENABLE, 8'h60, 2'b00);
    bus_write(`IDX_TIMER_MASK, 8'hFF);
    bus_read(`IDX_TIMER_MASK, 8'h02, 2'b00);
    bus_write(`IDX_RESET_CAUSE, 8'hFF);
    bus_read(`IDX_RESET_CAUSE, 8'h01, 2'b00);
    bus_read(6'h01, 8'h00, 2'b10);
    bus_write(`IDX_IRQ_ENABLE, 8'h00);
    pinLevel <= pinLevel ^ (6'($random(seed)) | 6'h01);
    repeat (8) @(posedge clk_sys);
    bus_read(`IDX_IRQ_FLAGS, 8'h20, 2'b00);
    bus_write(`IDX_IRQ_FLAGS, 8'h20);
    bus_read(`IDX_IRQ_FLAGS, 8'h00, 2'b00);
    bus_write(`IDX_PROC_CTRL, {6'h00, SENSE_RISE});
    extIrqPin <= 1'b1;
    pinLevel <= pinLevel ^ (6'($random(seed)) | 6'h01);
    repeat (8) @(posedge clk_sys);
    bus_read(`IDX_IRQ_FLAGS, 8'h60, 2'b00);
    bus_write(`IDX_IRQ_ENABLE, 8'h60);
    repeat (3) @(posedge clk_sys);
    `CHECK(irqRequest, 1'b0)
    vecQ.push_back(VEC_EXT);
    vecQ.push_back(VEC_PIN);
    ackDelay <= 4'h5;
    bus_write(`IDX_PROC_STATUS, 8'h80);
    `WAIT_FOR(irqAck)
    @(posedge clk_sys);
    `CHECK(globalEnable, 1'b0)
    returnFromInterrupt <= 1'b1;
    @(posedge clk_sys);
    returnFromInterrupt <= 1'b0;
    `WAIT_FOR(vecQ.size() == 0)
    bus_read(`IDX_IRQ_FLAGS, 8'h00, 2'b00);
    bus_read(`IDX_PROC_STATUS, 8'h00, 2'b00);
    ackDelay <= 4'h0;
    bus_write(`IDX_IRQ_ENABLE, 8'h00);
    bus_write(`IDX_PROC_CTRL, {6'h00, SENSE_LOW});
    bus_write(`IDX_IRQ_ENABLE, 8'h40);
    vecQ.push_back(VEC_EXT);
    bus_write(`IDX_PROC_STATUS, 8'h80);
    extIrqPin <= 1'b0;
    `WAIT_FOR(irqAck)
    bus_read(`IDX_IRQ_FLAGS, 8'h00, 2'b00);
    extIrqPin <= 1'b1;
    repeat (6) @(posedge clk_sys);
    returnFromInterrupt <= 1'b1;
    @(posedge clk_sys);
    returnFromInterrupt <= 1'b0;
    repeat (4) @(posedge clk_sys);
    `CHECK(irqRequest, 1'b0)
    vecQ.push_back(VEC_EXT);
    bus_write(`IDX_PROC_CTRL, {6'h00, SENSE_FALL});
    extIrqPin <= 1'b0;
    `WAIT_FOR(irqAck)
    bus_write(`IDX_PROC_CTRL, {6'h00, SENSE_ANY});
    extIrqPin <= 1'b1;
    repeat (8) @(posedge clk_sys);
    bus_read(`IDX_IRQ_FLAGS, 8'h40, 2'b00);
    wdtTimeout <= 1'b1;
    @(posedge clk_sys);
    wdtTimeout <= 1'b0;
    @(posedge clk_sys);
    `CHECK(wdtResetPulse, 1'b1)
    `WAIT_FOR(!coreReset)
    bus_read(`IDX_RESET_CAUSE, 8'h09, 2'b00);
    bus_write(`IDX_RESET_CAUSE, 8'h00);
    bus_read(`IDX_RESET_CAUSE, 8'h00, 2'b00);
    brownoutDetect <= 1'b1;
    repeat (6) @(posedge clk_sys);
    brownoutDetect <= 1'b0;
    `WAIT_FOR(!coreReset)
    bus_read(`IDX_RESET_CAUSE, 8'h04, 2'b00);
    bus_write(`IDX_RESET_CAUSE, 8'h00);
    extResetPinN <= 1'b0;
    repeat (6) @(posedge clk_sys);
    extResetPinN <= 1'b1;
    `WAIT_FOR(!coreReset)
    bus_read(`IDX_RESET_CAUSE, 8'h02, 2'b00);
    nrst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    `WAIT_FOR(!coreReset)
    bus_read(`IDX_RESET_CAUSE, 8'h01, 2'b00);
    repeat (4) @(posedge clk_sys);
    test_done();
  end
endmodule : testbench

`default_nettype wire
